// ### core/agc_map.svh
`ifndef AGC_MAP_SVH
`define AGC_MAP_SVH

// ----------------------------------------------------------------
// register indices and byte addresses (address = index * 4)
// ----------------------------------------------------------------
`define AGC_IDX_GAIN 4'hb
`define AGC_IDX_STAT 4'hc
`define AGC_IDX_CFG0 4'hd
`define AGC_ADDR_GAIN (8'({`AGC_IDX_GAIN, 2'b00}))
`define AGC_ADDR_STAT (8'({`AGC_IDX_STAT, 2'b00}))
`define AGC_ADDR_CFG0 (8'({`AGC_IDX_CFG0, 2'b00}))

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define AGC_GAIN_RST 24'h000000
`define AGC_STAT_RST 24'ha90000
`define AGC_CFG0_RST 24'h386050
`define AGC_GAIN_WMASK 24'hffffff
`define AGC_STAT_WMASK 24'hffc000
`define AGC_CFG0_WMASK 24'hffe0ff
`define AGC_FLAGS_RST 8'hff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AGC_STAT_RDINC_LSB 22
`define AGC_STAT_WRINC 21
`define AGC_STAT_IDLE 20
`define AGC_STAT_MERGE 19
`define AGC_STAT_CRCW 18
`define AGC_STAT_DW_LSB 16
`define AGC_STAT_CSUM_EN 15
`define AGC_STAT_IRQ_EN 14
`define AGC_CFG0_OFFCAL 23
`define AGC_CFG0_GAINCAL 22
`define AGC_CFG0_DITHER_LSB 20
`define AGC_CFG0_BOOST_LSB 18
`define AGC_CFG0_PRE_LSB 16
`define AGC_CFG0_OSR_LSB 13
`define AGC_CFG0_TRIM_LSB 0

// ----------------------------------------------------------------
// codes and timing counts
// ----------------------------------------------------------------
`define AGC_GAIN_MAX_CODE 3'd5
`define AGC_GAIN_UNITY 3'd0
`define AGC_OSR_BASE 13'd32
`define AGC_LOCK_PASSWORD 8'ha5
`define AGC_GAIN_CAL_DELAY 5'd24
`define AGC_READY_PULSE_CYC 3'd4
`define AGC_RESP_OKAY 2'b00
`define AGC_RESP_SLVERR 2'b10

`endif

// ### core/agc_pkg.sv
package agc_pkg;

  // ----------------------------------------------------------------
  // mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AGC_RD_SAME = 2'b00,
    AGC_RD_GROUP = 2'b01,
    AGC_RD_TYPE = 2'b10,
    AGC_RD_MAP = 2'b11
  } agc_read_incr_type;

  typedef enum logic [1:0] {
    AGC_DW_16_ROUND = 2'b00,
    AGC_DW_24 = 2'b01,
    AGC_DW_32_ZERO = 2'b10,
    AGC_DW_32_SIGN = 2'b11
  } agc_data_width_type;

  typedef enum logic [1:0] {
    AGC_PRE_DIV1 = 2'b00,
    AGC_PRE_DIV2 = 2'b01,
    AGC_PRE_DIV4 = 2'b10,
    AGC_PRE_DIV8 = 2'b11
  } agc_prescale_type;

  typedef logic [2:0] agc_gain_code_type;

endpackage

// ### core/agc_cfg_regs.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "agc_map.svh"
module agc_cfg_regs #(
  parameter int CHANNELS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CHANNELS-1:0] conv_ready,
  input wire logic modulator_digital_clock,
  input wire logic master_clk_tick,
  input wire logic map_checksum_error,
  input wire logic [15:0] map_checksum_value,
  input wire logic lock_write,
  input wire logic [7:0] lock_write_value,
  output logic [3*CHANNELS-1:0] channel_gain_code,
  output agc_pkg::agc_read_incr_type read_incr_mode,
  output logic write_incr_enable,
  output agc_pkg::agc_data_width_type data_width_mode,
  output logic link_checksum_wide,
  output logic link_checksum_enable,
  output logic offset_correction_enable,
  output logic gain_correction_enable,
  output logic [1:0] dither_strength,
  output logic [1:0] bias_current_sel,
  output logic analog_master_clock,
  output logic [12:0] oversampling_ratio,
  output logic [7:0] reference_tempco_trim,
  output logic [CHANNELS-1:0] channel_ready_events,
  output logic ready_output_pin_out,
  output logic ready_output_pin_oe
);
  import agc_pkg::*;

  // ----------------------------------------------------------------
  // register storage and status
  // ----------------------------------------------------------------
  logic [23:0] gain_reg;
  logic [23:0] stat_reg;
  logic [23:0] cfg0_reg;
  logic [CHANNELS-1:0] channel_ready_flags;
  logic map_irq;
  logic [CHANNELS-1:0] seen;
  logic [2:0] pulse_cnt;
  logic [2:0] pre_cnt;
  logic [4:0] delay_cnt [CHANNELS];
  logic [CHANNELS-1:0] ev;

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;
  logic rd_stat;

  // field views
  logic gaincal;
  logic merge;
  logic idle_drive;
  logic irq_en;
  logic [1:0] pre;
  assign gaincal = cfg0_reg[`AGC_CFG0_GAINCAL];
  assign merge = stat_reg[`AGC_STAT_MERGE];
  assign idle_drive = stat_reg[`AGC_STAT_IDLE];
  assign irq_en = stat_reg[`AGC_STAT_IRQ_EN];
  assign pre = cfg0_reg[`AGC_CFG0_PRE_LSB +: 2];

  // byte-lane merge of a write, unimplemented bits forced to zero
  function automatic logic [23:0] merge_write(
    input logic [23:0] old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [23:0] wmask
  );
    logic [23:0] lanes;
    lanes = {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_write = ((old & ~lanes) | (data[23:0] & lanes)) & wmask;
  endfunction

  // address decode helper
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `AGC_ADDR_GAIN) || (a == `AGC_ADDR_STAT) || (a == `AGC_ADDR_CFG0);
  endfunction

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write address holder
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awready && s_axi_awvalid)
    begin
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_go)
      s_axi_awready <= 1'b1;
  end

  // write data holder
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_wready <= 1'b1;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wready && s_axi_wvalid)
    begin
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_go)
      s_axi_wready <= 1'b1;
  end

  // write response
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AGC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_hit(aw_addr) ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // configuration registers; reserved status bits are not stored
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gain_reg <= `AGC_GAIN_RST;
      stat_reg <= `AGC_STAT_RST;
      cfg0_reg <= `AGC_CFG0_RST;
    end
    else if (wr_go)
    begin
      if (aw_addr == `AGC_ADDR_GAIN)
        gain_reg <= merge_write(gain_reg, w_data, w_strb, `AGC_GAIN_WMASK);
      if (aw_addr == `AGC_ADDR_STAT)
        stat_reg <= merge_write(stat_reg, w_data, w_strb, `AGC_STAT_WMASK);
      if (aw_addr == `AGC_ADDR_CFG0)
        cfg0_reg <= merge_write(cfg0_reg, w_data, w_strb, `AGC_CFG0_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // read channel, one cycle answer
  // ----------------------------------------------------------------
  assign rd_go = s_axi_arready && s_axi_arvalid;
  assign rd_stat = rd_go && (s_axi_araddr == `AGC_ADDR_STAT);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AGC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_hit(s_axi_araddr) ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
      unique case (1'b1)
        s_axi_araddr == `AGC_ADDR_GAIN: s_axi_rdata <= {8'h00, gain_reg};
        s_axi_araddr == `AGC_ADDR_STAT:
          s_axi_rdata <= {8'h00, stat_reg[23:8], channel_ready_flags};
        s_axi_araddr == `AGC_ADDR_CFG0: s_axi_rdata <= {8'h00, cfg0_reg};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel ready delay and gain decode
  // ----------------------------------------------------------------
  for (genvar n = 0; n < CHANNELS; n++)
  begin : g_chan
    // gain correction delays ready by modulator clock periods
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        delay_cnt[n] <= 5'd0;
      else if (conv_ready[n] && gaincal)
        delay_cnt[n] <= `AGC_GAIN_CAL_DELAY;
      else if (modulator_digital_clock && delay_cnt[n] != 5'd0)
        delay_cnt[n] <= delay_cnt[n] - 5'd1;
    end

    // offset correction path adds nothing, so the event is immediate
    assign ev[n] = gaincal ? (modulator_digital_clock && delay_cnt[n] == 5'd1)
                           : conv_ready[n];

    // reserved gain codes fall back to unity
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        channel_gain_code[3*n +: 3] <= `AGC_GAIN_UNITY;
      else if (gain_reg[3*n +: 3] > `AGC_GAIN_MAX_CODE)
        channel_gain_code[3*n +: 3] <= `AGC_GAIN_UNITY;
      else
        channel_gain_code[3*n +: 3] <= gain_reg[3*n +: 3];
    end

    property p_gain_load;
      @(posedge core_clk) disable iff (!rst_n)
      (gaincal && conv_ready[n]) |=> delay_cnt[n] == `AGC_GAIN_CAL_DELAY;
    endproperty
    a_gain_load: assert property (p_gain_load)
      else $error("gain correction delay not loaded");

    property p_gain_bypass;
      @(posedge core_clk) disable iff (!rst_n)
      !gaincal |-> ev[n] == conv_ready[n];
    endproperty
    a_gain_bypass: assert property (p_gain_bypass)
      else $error("ready event delayed without gain correction");
  end

  // ----------------------------------------------------------------
  // ready flags, pin pulse and checksum interrupt
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] all_seen;
  logic pulse_req;
  logic [2:0] next_pulse_cnt;
  logic next_map_irq;
  assign all_seen = seen | ev;
  assign pulse_req = merge ? (&all_seen) : (|ev);
  assign next_pulse_cnt = pulse_req ? `AGC_READY_PULSE_CYC
                        : (pulse_cnt != 3'd0 ? pulse_cnt - 3'd1 : 3'd0);
  assign next_map_irq = (map_irq && !(lock_write && lock_write_value == `AGC_LOCK_PASSWORD))
                      || (irq_en && map_checksum_error);

  // flags: event clearing wins over the read that sets them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      channel_ready_flags <= `AGC_FLAGS_RST;
    else
      channel_ready_flags <= (channel_ready_flags | {CHANNELS{rd_stat}}) & ~ev;
  end

  // channels seen since the last merged pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      seen <= '0;
    else if (!merge || (&all_seen))
      seen <= '0;
    else
      seen <= all_seen;
  end

  // pin pulse counter and latched interrupt
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pulse_cnt <= 3'd0;
      map_irq <= 1'b0;
      channel_ready_events <= '0;
    end
    else
    begin
      pulse_cnt <= next_pulse_cnt;
      map_irq <= next_map_irq;
      channel_ready_events <= ev;
    end
  end

  // pin: low during pulse or interrupt, else high or released
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ready_output_pin_out <= 1'b1;
      ready_output_pin_oe <= 1'b0;
    end
    else
    begin
      ready_output_pin_out <= !(next_pulse_cnt != 3'd0 || next_map_irq);
      ready_output_pin_oe <= next_pulse_cnt != 3'd0 || next_map_irq || idle_drive;
    end
  end

  // ----------------------------------------------------------------
  // analog clock prescaler and oversampling decode
  // ----------------------------------------------------------------
  logic [2:0] pre_mask;
  assign pre_mask = 3'((4'd1 << pre) - 4'd1);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pre_cnt <= 3'd0;
      analog_master_clock <= 1'b0;
    end
    else
    begin
      analog_master_clock <= master_clk_tick && (pre_cnt & pre_mask) == pre_mask;
      if (master_clk_tick)
        pre_cnt <= ((pre_cnt & pre_mask) == pre_mask) ? 3'd0 : pre_cnt + 3'd1;
    end
  end

  // oversampling ratio doubles per code
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      oversampling_ratio <= 13'(`AGC_OSR_BASE << 3'(`AGC_CFG0_RST >> `AGC_CFG0_OSR_LSB));
    else
      oversampling_ratio <= 13'(`AGC_OSR_BASE << cfg0_reg[`AGC_CFG0_OSR_LSB +: 3]);
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign read_incr_mode = agc_read_incr_type'(stat_reg[`AGC_STAT_RDINC_LSB +: 2]);
  assign write_incr_enable = stat_reg[`AGC_STAT_WRINC];
  assign data_width_mode = agc_data_width_type'(stat_reg[`AGC_STAT_DW_LSB +: 2]);
  assign link_checksum_wide = stat_reg[`AGC_STAT_CRCW];
  assign link_checksum_enable = stat_reg[`AGC_STAT_CSUM_EN];
  assign offset_correction_enable = cfg0_reg[`AGC_CFG0_OFFCAL];
  assign gain_correction_enable = gaincal;
  assign dither_strength = cfg0_reg[`AGC_CFG0_DITHER_LSB +: 2];
  assign bias_current_sel = cfg0_reg[`AGC_CFG0_BOOST_LSB +: 2];
  assign reference_tempco_trim = cfg0_reg[`AGC_CFG0_TRIM_LSB +: 8];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_stat_read_sets;
    (rd_stat && ev == '0) |=> channel_ready_flags == `AGC_FLAGS_RST;
  endproperty
  a_stat_read_sets: assert property (p_stat_read_sets)
    else $error("status read did not set ready flags");

  property p_flag_on_event;
    (ev != '0) |=> ((channel_ready_flags & $past(ev)) == '0);
  endproperty
  a_flag_on_event: assert property (p_flag_on_event)
    else $error("ready event did not clear its flag");

  property p_flags_only_by_read;
    !rd_stat |=> ((channel_ready_flags & ~$past(channel_ready_flags)) == '0);
  endproperty
  a_flags_only_by_read: assert property (p_flags_only_by_read)
    else $error("ready flag set without status read");

  property p_irq_holds_low;
    map_irq |-> (!ready_output_pin_out && ready_output_pin_oe);
  endproperty
  a_irq_holds_low: assert property (p_irq_holds_low)
    else $error("interrupt did not hold ready pin low");

  property p_irq_disabled;
    (!irq_en && !map_irq) |=> !map_irq;
  endproperty
  a_irq_disabled: assert property (p_irq_disabled)
    else $error("interrupt raised while disabled");

  property p_irq_clear;
    (map_irq && lock_write && lock_write_value == `AGC_LOCK_PASSWORD
      && !(irq_en && map_checksum_error)) |=> !map_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("password write did not clear interrupt");

  property p_idle_release;
    (ready_output_pin_oe && ready_output_pin_out) |-> $past(idle_drive);
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("ready pin driven high while idle drive off");

  property p_pulse_per_channel;
    (!merge && ev != '0) |=> !ready_output_pin_out ##1 (pulse_cnt != 3'd0);
  endproperty
  a_pulse_per_channel: assert property (p_pulse_per_channel)
    else $error("channel event gave no ready pulse");

  property p_gain_reserved;
    (gain_reg[2:0] > `AGC_GAIN_MAX_CODE) |=> channel_gain_code[2:0] == `AGC_GAIN_UNITY;
  endproperty
  a_gain_reserved: assert property (p_gain_reserved)
    else $error("reserved gain code not mapped to unity");

  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unimplemented read bits not zero");

endmodule

// ### verification/agc_host_model.sv
`timescale 1ns/100ps
// host side of the register bus, bready and rready held high
module agc_host_model (
  input wire logic core_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus at time zero
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end

  // one write, each channel dropped at its own take
  task automatic wr(input logic [7:0] a, input logic [23:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {8'h00, d & ((a == 8'h30) ? 24'hffcfff : 24'hffffff)};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      aw |= s_axi_awvalid & s_axi_awready;
      w |= s_axi_wvalid & s_axi_wready;
      s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
    end
    while (!(aw && w));
    // released payload does not keep its value
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~s_axi_wdata;
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import agc_pkg::*;

  // ----------------------------
  // signals and instances
  // ----------------------------
  logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, conv_ready, lock_write_value, reference_tempco_trim;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, v, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, dither_strength, bias_current_sel, rr;
  logic modulator_digital_clock, master_clk_tick, map_checksum_error, lock_write, prev_low;
  logic [15:0] map_checksum_value;
  logic [23:0] channel_gain_code;
  agc_read_incr_type read_incr_mode;
  agc_data_width_type data_width_mode;
  logic write_incr_enable, link_checksum_wide, link_checksum_enable, offset_correction_enable;
  logic gain_correction_enable, analog_master_clock, ready_output_pin_out, ready_output_pin_oe;
  logic [12:0] oversampling_ratio;
  logic [7:0] channel_ready_events, flags_m;
  int err_total, checked, pulses, lows, p, l, d0, n1, gain_m, stat_m;
  wire pin_low = ready_output_pin_oe & ~ready_output_pin_out;

  agc_cfg_regs dut_u (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conv_ready, .modulator_digital_clock, .master_clk_tick,
    .map_checksum_error, .map_checksum_value, .lock_write, .lock_write_value,
    .channel_gain_code, .read_incr_mode, .write_incr_enable, .data_width_mode,
    .link_checksum_wide, .link_checksum_enable, .offset_correction_enable,
    .gain_correction_enable, .dither_strength, .bias_current_sel, .analog_master_clock,
    .oversampling_ratio, .reference_tempco_trim, .channel_ready_events,
    .ready_output_pin_out, .ready_output_pin_oe);

  agc_host_model host_u (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // ----------------------------
  // clock, pin monitor, helpers
  // ----------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // counts ready pin pulses and low cycles
  always @(posedge core_clk)
  begin
    prev_low <= pin_low;
    pulses <= pulses + (pin_low & ~prev_low & rst_n);
    lows <= lows + (pin_low & rst_n);
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    host_u.rd(a, rv, rr);
    chk("rdata", e, rv);
    chk("rresp", {30'h0, er}, {30'h0, rr});
    if (a == 8'h30)
      flags_m = 8'hff;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [23:0] d, input logic [1:0] er);
    host_u.wr(a, d, rr);
    chk("bresp", {30'h0, er}, {30'h0, rr});
    repeat (2) @(posedge core_clk);
  endtask

  // one conversion event, returns cycles until the pin goes low
  task automatic fire(input logic [7:0] m, output int n);
    logic [7:0] evs;
    evs = 8'h00;
    conv_ready <= m;
    @(posedge core_clk);
    conv_ready <= 8'h00;
    n = 0;
    while (pin_low !== 1'b1 && n < 60)
    begin
      @(posedge core_clk);
      n++;
      evs |= channel_ready_events;
    end
    evs |= channel_ready_events;
    chk("events", {24'h0, m}, {24'h0, evs});
    flags_m &= ~m;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_sim();
  end

  // ----------------------------
  // scenarios
  // ----------------------------
  initial
  begin
    {err_total, checked, pulses, lows, prev_low, rst_n, lock_write} = '0;
    {conv_ready, map_checksum_error, map_checksum_value, lock_write_value} = '0;
    {modulator_digital_clock, master_clk_tick} = 2'h3;
    lfsr = 32'h69fbf1a4;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    flags_m = 8'hff;
    rdc(8'h2c, 32'h0, 2'b00);
    rdc(8'h30, 32'ha900ff, 2'b00);
    rdc(8'h34, 32'h386050, 2'b00);
    chk("osr", 32'd256, {19'h0, oversampling_ratio});
    chk("idle_oe", 32'h0, {31'h0, ready_output_pin_oe});
    // every gain code, then a random word
    for (int i = 0; i < 2; i++)
    begin
      v = i ? lfsr : 32'hfac688;
      gain_m = v[23:0];
      wrc(8'h2c, v[23:0], 2'b00);
      rdc(8'h2c, gain_m, 2'b00);
      for (int c = 0; c < 8; c++)
        chk("gain", (v[3*c+:3] > 5) ? 0 : v[3*c+:3], channel_gain_code[3*c+:3]);
      lfsr = nxt(lfsr);
    end
    // status modes with stray low bits written
    for (int i = 0; i < 4; i++)
    begin
      v = (lfsr & 32'h3cc000) | i * 32'h410000;
      wrc(8'h30, v[23:0] | 24'h003fff, 2'b00);
      rdc(8'h30, v | flags_m, 2'b00);
      chk("stat", {v[23:21], v[18:15]}, {read_incr_mode, write_incr_enable,
        link_checksum_wide, data_width_mode, link_checksum_enable});
      chk("pin", {v[20], v[20]}, {ready_output_pin_oe, ready_output_pin_out & v[20]});
      lfsr = nxt(lfsr);
    end
    // config fields, every oversampling and two-bit code
    for (int i = 0; i < 8; i++)
    begin
      v = (lfsr & 32'hc000ff) | (i % 4) * 32'h150000 | (i << 13);
      map_checksum_value <= lfsr[15:0];
      wrc(8'h34, v[23:0] | 24'h001f00, 2'b00);
      rdc(8'h34, v, 2'b00);
      chk("osr", 32 << i, {19'h0, oversampling_ratio});
      chk("fields", v[23:18], {offset_correction_enable, gain_correction_enable,
        dither_strength, bias_current_sel});
      chk("trim", v[7:0], reference_tempco_trim);
      n1 = 0;
      repeat (32)
      begin
        @(posedge core_clk);
        n1 += analog_master_clock;
      end
      chk("analog_master_clock", 32 >> v[17:16], n1);
      lfsr = nxt(lfsr);
    end
    wrc(8'h34, 24'h386050, 2'b00);
    // one pulse per channel, flag ready until status read
    stat_m = 32'ha10000;
    wrc(8'h30, 24'ha10000, 2'b00);
    for (int k = 0; k < 8; k++)
    begin
      p = pulses;
      l = lows;
      fire(8'h01 << k, n1);
      d0 = (k == 0) ? n1 : d0;
      chk("pulses", p + 1, pulses);
      chk("lows", l + 4, lows);
      rdc(8'h2c, gain_m, 2'b00);
      rdc(8'h30, stat_m | flags_m, 2'b00);
    end
    rdc(8'h30, stat_m | 32'hff, 2'b00);
    // delay from gain correction only
    wrc(8'h34, 24'h786050, 2'b00);
    fire(8'h01, n1);
    chk("gain_delay", d0 + 24, n1);
    wrc(8'h34, 24'hb86050, 2'b00);
    fire(8'h01, n1);
    chk("off_delay", d0, n1);
    // merged pulse after the last channel
    wrc(8'h30, 24'ha90000, 2'b00);
    p = pulses;
    for (int k = 0; k < 8; k++)
    begin
      fire(8'h01 << k, n1);
      chk("merged", p + (k == 7), pulses);
    end
    // checksum error silent when disabled, held until password
    map_checksum_error <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("irq_off", 32'h0, {31'h0, pin_low});
    wrc(8'h30, 24'ha94000, 2'b00);
    map_checksum_error <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      lock_write <= 1'b1;
      lock_write_value <= i ? 8'ha5 : 8'h5a;
      @(posedge core_clk);
      lock_write <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("irq_pin", !i, {31'h0, pin_low});
    end
    // unmapped address
    wrc(8'h40, lfsr[23:0], 2'b10);
    rdc(8'h40, 32'h0, 2'b10);
    end_sim();
  end
endmodule
